// [motion_pause_resume_control_bench.sv]
/*
 * Self-checking bench for the pause and resume control, with a driver model.
 * Assumes a 25 MHz clock and synchronous active-low reset on i_rst_n.
 */
`timescale 1ns/1ns
module motion_pause_resume_control_bench;
    logic i_clk, i_rst_n, i_hold_cmd, i_hold_pin, i_hold_rio, i_rio_hold_assigned;
    logic i_resume_motion_cmd, i_resume_pin, i_hold_clear_cmd, i_hold_clear_input;
    logic i_start_pin, i_seq_running, i_move_cmd, i_step_done, i_held_active_level;
    mpr_pkg::mpr_kind_t i_move_kind, o_kind;
    logic [31:0] i_move_dist, o_remaining, rem;
    logic [15:0] i_move_vel, o_vel, v;
    logic o_motion_active, o_dir_neg, o_held_status_signal, o_held_pin, lvl;
    logic o_start_active_flag, o_resumed;
    int n_start_act, n_resumed, base;
    int n_mismatch = 0;
    int num_checks = 0;
    integer seed = 32'hDD29EFA7;

    mpr_ctrl mpr_ctrl_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hold_cmd(i_hold_cmd),
        .i_hold_pin(i_hold_pin), .i_hold_rio(i_hold_rio),
        .i_rio_hold_assigned(i_rio_hold_assigned), .i_resume_motion_cmd(i_resume_motion_cmd),
        .i_resume_pin(i_resume_pin), .i_hold_clear_cmd(i_hold_clear_cmd),
        .i_hold_clear_input(i_hold_clear_input), .i_start_pin(i_start_pin),
        .i_seq_running(i_seq_running), .i_move_cmd(i_move_cmd), .i_move_kind(i_move_kind),
        .i_move_dist(i_move_dist), .i_move_vel(i_move_vel), .i_step_done(i_step_done),
        .i_held_active_level(i_held_active_level), .o_motion_active(o_motion_active),
        .o_vel(o_vel), .o_dir_neg(o_dir_neg), .o_kind(o_kind), .o_remaining(o_remaining),
        .o_held_status_signal(o_held_status_signal), .o_held_pin(o_held_pin),
        .o_start_active_flag(o_start_active_flag), .o_resumed(o_resumed));
    mpr_drive_model mpr_drive_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_motion_active(o_motion_active), .i_vel(o_vel), .o_step_done(i_step_done));

    // Free-running 40 ns clock
    always #20 i_clk = ~i_clk;

    // Tally of flag cycles and resume pulses; both are short-lived, so counts are compared
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            n_start_act <= 0;
            n_resumed <= 0;
        end else begin
            n_start_act <= n_start_act + int'(o_start_active_flag === 1'b1);
            n_resumed <= n_resumed + int'(o_resumed === 1'b1);
        end
    end

    task automatic final_report;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Selector keeps one pulse task for every request line
    task automatic drive(input int s, input logic b);
        case (s)
            0: i_hold_cmd <= b;
            1: i_hold_pin <= b;
            2: i_hold_rio <= b;
            3: i_resume_motion_cmd <= b;
            4: i_resume_pin <= b;
            5: i_hold_clear_cmd <= b;
            6: i_hold_clear_input <= b;
            7: i_start_pin <= b;
            default: i_move_cmd <= b;
        endcase
    endtask : drive

    // Strobes last one cycle; pins stay up long enough to pass the synchroniser
    task automatic hit(input int s);
        @(posedge i_clk);
        drive(s, 1'b1);
        repeat ((s == 0 || s == 3 || s == 5 || s == 8) ? 1 : 4) @(posedge i_clk);
        drive(s, 1'b0);
        repeat (5) @(posedge i_clk);
    endtask : hit

    task automatic launch(input int k, input logic [15:0] sp);
        @(posedge i_clk);
        i_move_kind <= mpr_pkg::mpr_kind_t'(k[2:0]);
        i_move_dist <= 32'h00000100 + 32'($random(seed) & 8'hFF);
        i_move_vel <= sp;
        i_held_active_level <= lvl;
        hit(8);
    endtask : launch

    // Bounded wait for held (w=1) or for motion to stop (w=0)
    task automatic wait_st(input logic w);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(negedge i_clk);
            if (w ? o_held_status_signal === 1'b1 : o_motion_active === 1'b0) break;
        end
        if (i == 3000) begin
            n_mismatch++;
            final_report();
        end
    endtask : wait_st

    // Main sequence
    initial begin
        {i_clk, i_rst_n, i_hold_cmd, i_hold_pin, i_hold_rio, i_resume_motion_cmd} = '0;
        {i_resume_pin, i_hold_clear_cmd, i_hold_clear_input, i_start_pin, i_move_cmd} = '0;
        {i_seq_running, i_rio_hold_assigned, i_held_active_level, lvl} = 4'hC;
        i_move_kind = mpr_pkg::MPR_MV_INC;
        i_move_dist = 32'h00000000;
        i_move_vel = 16'h0000;
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        hit(0);
        @(negedge i_clk);
        chk({o_held_status_signal, o_motion_active, o_vel}, 0); // Idle hold
        hit(7);
        chk(n_start_act != 0, 1); // Start press outside hold raises the flag
        for (int k = 0; k < 7; k++) begin
            v = 16'h0002 + 16'($random(seed) & 3);
            lvl = 1'($random(seed));
            launch(k, v);
            hit(k % 3); // Hold from command, pin or fieldbus bit
            @(negedge i_clk);
            chk({o_held_status_signal, o_motion_active && o_vel != 16'h0000}, 2'b01);
            if (k < 4) begin
                chk(o_dir_neg, k == 3); // Direction kept
                wait_st(1'b1);
                rem = o_remaining;
                chk({o_held_pin, o_kind}, {lvl, 3'(k)}); // Status pin level
                hit(0);
                @(negedge i_clk);
                chk({o_held_status_signal, o_remaining}, {1'b1, rem});
                base = n_start_act;
                hit(k == 3 ? 7 : (k == 1 ? 4 : 3)); // Resume paths
                @(negedge i_clk);
                chk({o_motion_active, o_held_status_signal, o_vel}, {2'b10, v});
                chk(o_kind, k); // Same move relaunched
                chk(n_resumed, k + 1); // One resume pulse each
                if (k == 3) begin
                    chk(n_start_act, base); // Flag stays low on resume
                end
                hit(0);
                wait_st(1'b1);
                chk({o_held_status_signal, o_motion_active, o_vel}, {2'b10, 16'h0000});
                hit(5);
                hit(3);
                @(negedge i_clk);
                chk({o_held_status_signal, o_motion_active, o_held_pin, o_remaining},
                    {2'b00, ~lvl, 32'h00000000});
            end else begin
                wait_st(1'b0);
                hit(3);
                @(negedge i_clk);
                chk({o_held_status_signal, o_motion_active, o_vel}, 0); // No resume
                chk(n_resumed, 4); // Resume ignored
            end
        end
        launch(0, 16'h0003);
        @(posedge i_clk);
        i_rio_hold_assigned <= 1'b0;
        hit(2);
        repeat (30) @(posedge i_clk); // Longer than one ramp tick, so a ramp would show
        @(negedge i_clk);
        chk(o_vel, 3); // Unassigned fieldbus bit ignored
        @(posedge i_clk);
        i_rio_hold_assigned <= 1'b1;
        hit(0);
        wait_st(1'b1);
        launch(1, 16'h0004);
        @(negedge i_clk);
        chk({o_held_status_signal, o_vel, o_kind}, {1'b0, 16'h0004, 3'h1});
        hit(0);
        wait_st(1'b1);
        hit(6);
        @(negedge i_clk);
        chk({o_held_status_signal, o_motion_active, o_remaining}, 0); // Clear input
        final_report();
    end
endmodule : motion_pause_resume_control_bench

// [mpr_ctrl.sv]
/*
 * Motion pause and resume control: takes hold requests, ramps the move
 * down, keeps the unfinished remainder and relaunches or drops it.
 * Assumes host strobes are one-cycle pulses on i_clk; pins are asynchronous.
 */
`timescale 1ns/1ns
module mpr_ctrl #(
    parameter int POS_W = mpr_pkg::POS_W,
    parameter int VEL_W = mpr_pkg::VEL_W,
    parameter logic [15:0] DECEL_STEP = 16'(mpr_pkg::DECEL_STEP_DEF)
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hold_cmd,
    input wire logic i_hold_pin,
    input wire logic i_hold_rio,
    input wire logic i_rio_hold_assigned,
    input wire logic i_resume_motion_cmd,
    input wire logic i_resume_pin,
    input wire logic i_hold_clear_cmd,
    input wire logic i_hold_clear_input,
    input wire logic i_start_pin,
    input wire logic i_seq_running,
    input wire logic i_move_cmd,
    input wire mpr_pkg::mpr_kind_t i_move_kind,
    input wire logic [POS_W-1:0] i_move_dist,
    input wire logic [VEL_W-1:0] i_move_vel,
    input wire logic i_step_done,
    input wire logic i_held_active_level,
    output logic o_motion_active,
    output logic [VEL_W-1:0] o_vel,
    output logic o_dir_neg,
    output mpr_pkg::mpr_kind_t o_kind,
    output logic [POS_W-1:0] o_remaining,
    output logic o_held_status_signal,
    output logic o_held_pin,
    output logic o_start_active_flag,
    output logic o_resumed
);
    // Velocity step is only 16 bits wide, so wider speeds cannot be served
    if (POS_W < 8 || VEL_W < 4 || VEL_W > 16) begin : g_width_check
        $error("mpr_ctrl: unsupported width");
    end

    typedef struct packed {
        mpr_pkg::mpr_state_t state;
        mpr_pkg::mpr_kind_t kind;
        logic [POS_W-1:0] remain;
        logic [VEL_W-1:0] vel_set;
        logic [VEL_W-1:0] vel;
        logic held;
        logic start_act;
        logic resumable;
        logic resumed;
        logic [15:0] tick;
        logic pins_d;
        logic hold_lvl_d;
        logic rio_d;
        logic start_d;
    } mpr_ctrl_t;

    mpr_ctrl_t st_ff;
    mpr_ctrl_t nxt_st;
    logic [4:0] pins_s;
    logic hold_pin_s, resume_pin_s, clear_pin_s, start_pin_s, rio_s;
    logic hold_req, resume_req, clear_req, start_edge, tick_en;

    mpr_sync #(
        .WIDTH(5)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_hold_pin, i_resume_pin, i_hold_clear_input, i_start_pin, i_hold_rio}),
        .o_sync(pins_s)
    );
    assign {hold_pin_s, resume_pin_s, clear_pin_s, start_pin_s, rio_s} = pins_s;

    // Resumable kinds only; linked and homing moves are not
    function automatic logic can_resume(input mpr_pkg::mpr_kind_t k);
        can_resume = (k == mpr_pkg::MPR_MV_INC) || (k == mpr_pkg::MPR_MV_ABS) ||
                     (k == mpr_pkg::MPR_MV_CPOS) || (k == mpr_pkg::MPR_MV_CNEG);
    endfunction : can_resume

    // Continuous moves have no end point, so their distance never counts down
    function automatic logic counts_dist(input mpr_pkg::mpr_kind_t k);
        counts_dist = (k != mpr_pkg::MPR_MV_CPOS) && (k != mpr_pkg::MPR_MV_CNEG);
    endfunction : counts_dist

    // Edge detection on synchronised hold, resume, fieldbus and start pins; clear pin is used as a level; pulses merge with host strobes
    assign hold_req = i_hold_cmd || (hold_pin_s && !st_ff.hold_lvl_d) ||
                      (i_rio_hold_assigned && rio_s && !st_ff.rio_d);
    assign resume_req = i_resume_motion_cmd || (resume_pin_s && !st_ff.pins_d);
    assign clear_req = i_hold_clear_cmd || clear_pin_s;
    assign start_edge = start_pin_s && !st_ff.start_d && i_seq_running;
    assign tick_en = (st_ff.tick == mpr_pkg::RAMP_TICK_DIV);

    // Next-state logic for the whole controller
    always_comb begin
        nxt_st = st_ff;
        nxt_st.resumed = 1'b0;
        nxt_st.pins_d = resume_pin_s;
        nxt_st.hold_lvl_d = hold_pin_s;
        nxt_st.rio_d = rio_s;
        nxt_st.start_d = start_pin_s;
        // A press that resumes a held move never raises the flag
        nxt_st.start_act = start_pin_s && (st_ff.start_act || (!st_ff.start_d &&
                           !(st_ff.state == mpr_pkg::MPR_ST_HELD && i_seq_running)));
        nxt_st.tick = tick_en ? 16'h0000 : st_ff.tick + 16'h0001;
        unique case (st_ff.state)
            mpr_pkg::MPR_ST_IDLE: begin
                // Hold while idle is ignored entirely
                if (i_move_cmd) begin
                    nxt_st.state = mpr_pkg::MPR_ST_RUN;
                    nxt_st.kind = i_move_kind;
                    nxt_st.remain = i_move_dist;
                    nxt_st.vel_set = i_move_vel;
                    nxt_st.vel = i_move_vel;
                end
            end
            mpr_pkg::MPR_ST_RUN: begin
                if (i_step_done && st_ff.remain != '0 && counts_dist(st_ff.kind)) begin
                    nxt_st.remain = st_ff.remain - POS_W'(1);
                end
                if (hold_req) begin
                    nxt_st.state = mpr_pkg::MPR_ST_DECEL;
                    nxt_st.resumable = can_resume(st_ff.kind);
                end else if (st_ff.remain == '0 && counts_dist(st_ff.kind)) begin
                    nxt_st.state = mpr_pkg::MPR_ST_IDLE;
                    nxt_st.vel = '0;
                end
            end
            mpr_pkg::MPR_ST_DECEL: begin
                // Remaining distance still counts down while ramping
                if (i_step_done && st_ff.remain != '0 && counts_dist(st_ff.kind)) begin
                    nxt_st.remain = st_ff.remain - POS_W'(1);
                end
                if (tick_en) begin
                    if (st_ff.vel <= DECEL_STEP[VEL_W-1:0]) begin
                        nxt_st.vel = '0;
                        nxt_st.state = st_ff.resumable ? mpr_pkg::MPR_ST_HELD
                                                       : mpr_pkg::MPR_ST_IDLE;
                        nxt_st.held = st_ff.resumable;
                    end else begin
                        nxt_st.vel = st_ff.vel - DECEL_STEP[VEL_W-1:0];
                    end
                end
            end
            mpr_pkg::MPR_ST_HELD: begin
                // Kind, remainder and set speed kept until a new move; a clear zeroes the remainder
                if (i_move_cmd) begin
                    nxt_st.state = mpr_pkg::MPR_ST_RUN;
                    nxt_st.held = 1'b0;
                    nxt_st.kind = i_move_kind;
                    nxt_st.remain = i_move_dist;
                    nxt_st.vel_set = i_move_vel;
                    nxt_st.vel = i_move_vel;
                end else if (clear_req) begin
                    nxt_st.state = mpr_pkg::MPR_ST_IDLE;
                    nxt_st.held = 1'b0;
                    nxt_st.remain = '0;
                end else if (resume_req || start_edge) begin
                    nxt_st.state = mpr_pkg::MPR_ST_RUN;
                    nxt_st.held = 1'b0;
                    nxt_st.vel = st_ff.vel_set;
                    nxt_st.resumed = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Sequence flag only gates the start pin and is not passed out; hold never clears the start flag
    assign o_motion_active = (st_ff.state == mpr_pkg::MPR_ST_RUN) ||
                             (st_ff.state == mpr_pkg::MPR_ST_DECEL);
    assign o_vel = st_ff.vel;
    assign o_dir_neg = (st_ff.kind == mpr_pkg::MPR_MV_CNEG);
    assign o_kind = st_ff.kind;
    assign o_remaining = st_ff.remain;
    assign o_held_status_signal = st_ff.held;
    assign o_held_pin = st_ff.held ? i_held_active_level : !i_held_active_level;
    assign o_start_active_flag = st_ff.start_act;
    assign o_resumed = st_ff.resumed;

    sequence s_ramp_entry;
        st_ff.state == mpr_pkg::MPR_ST_RUN && hold_req;
    endsequence

    chk_hold_ramps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_ramp_entry |=> st_ff.state == mpr_pkg::MPR_ST_DECEL && st_ff.vel != '0 || !o_motion_active)
        else $error("hold did not enter ramp");
    chk_idle_hold_noop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_ff.state == mpr_pkg::MPR_ST_IDLE && !i_move_cmd |=> st_ff.state == mpr_pkg::MPR_ST_IDLE
        && !o_held_status_signal) else $error("idle hold changed state");
    chk_held_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_ff.state == mpr_pkg::MPR_ST_HELD && !i_move_cmd |=> $stable(o_kind) &&
        (o_remaining == $past(o_remaining) || o_remaining == '0)) else $error("retained move lost");
    chk_clear_drops: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_ff.state == mpr_pkg::MPR_ST_HELD && clear_req && !i_move_cmd |=>
        o_remaining == '0 && !o_held_status_signal) else $error("clear kept remainder");
    chk_held_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_held_status_signal == (st_ff.state == mpr_pkg::MPR_ST_HELD)) else $error("held flag wrong");
    chk_nohome_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_ff.state == mpr_pkg::MPR_ST_DECEL && !st_ff.resumable |-> !nxt_st.held)
        else $error("homing move held");
    chk_resume_runs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_ff.state == mpr_pkg::MPR_ST_HELD && resume_req && !clear_req && !i_move_cmd |=>
        o_resumed && o_vel == $past(st_ff.vel_set)) else $error("resume failed");
    chk_pin_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_held_status_signal |-> o_held_pin == i_held_active_level) else $error("held pin level");
    chk_rehold_noop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_ff.state == mpr_pkg::MPR_ST_HELD && hold_req && !resume_req && !clear_req &&
        !i_move_cmd && !start_edge |=> o_held_status_signal) else $error("rehold changed hold");
    chk_start_flag_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_ff.state == mpr_pkg::MPR_ST_HELD && start_edge |=> !o_start_active_flag)
        else $error("start flag raised on resume");
endmodule : mpr_ctrl

// [mpr_drive_model.sv]
/*
 * Motor driver stand-in: turns the speed command into step-done pulses.
 * Assumes the controller's 25 MHz clock and its synchronous active-low reset.
 */
`timescale 1ns/1ns
module mpr_drive_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_motion_active,
    input wire logic [15:0] i_vel,
    output logic o_step_done
);
    logic [8:0] acc_ff;

    // Phase accumulator, so the step rate follows the commanded speed
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !i_motion_active) begin
            acc_ff <= 9'h000; // No steps while stopped or held
        end else begin
            acc_ff <= {1'b0, acc_ff[7:0]} + {1'b0, i_vel[7:0]};
        end
    end

    // One pulse per overflow; only small speeds are used, so it never stands
    assign o_step_done = acc_ff[8];
endmodule : mpr_drive_model

// [mpr_pkg.sv]
/*
 * Shared constants and types for the motion pause and resume control.
 * Assumes a single 25 MHz clock and plain command strobes from the host side.
 */
package mpr_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int POS_W = 32;
    localparam int VEL_W = 16;
    localparam int DECEL_STEP_DEF = 1;
    localparam logic [15:0] RAMP_TICK_DIV = 16'h0019;
    localparam logic [31:0] POS_RST = 32'h00000000;
    localparam logic [15:0] VEL_RST = 16'h0000;

    // Kind of the move in progress
    typedef enum logic [2:0] {
        MPR_MV_INC = 3'b000,
        MPR_MV_ABS = 3'b001,
        MPR_MV_CPOS = 3'b010,
        MPR_MV_CNEG = 3'b011,
        MPR_MV_LINK = 3'b100,
        MPR_MV_EHOME = 3'b101,
        MPR_MV_MHOME = 3'b110
    } mpr_kind_t;

    typedef enum logic [1:0] {
        MPR_ST_IDLE = 2'b00,
        MPR_ST_RUN = 2'b01,
        MPR_ST_DECEL = 2'b10,
        MPR_ST_HELD = 2'b11
    } mpr_state_t;
endpackage : mpr_pkg

// [mpr_sync.sv]
/*
 * Two-stage synchroniser for the external hold, resume, clear and start pins and the fieldbus hold bit.
 * Assumes the pins are asynchronous to i_clk; output is a clean level.
 */
`timescale 1ns/1ns
module mpr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } mpr_sync_t;

    mpr_sync_t st_ff;
    mpr_sync_t nxt_st;

    // First stage feeds only the second
    always_comb begin
        nxt_st.meta = i_async;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_sync = st_ff.sync;
endmodule : mpr_sync
